// *** rtl/cpsr_pkg.sv ***
// Notes on behaviour
// - counter advances on clock rise only while chip enable low and reset high
// - reset pin low clears counter and floats data outputs
// - reset pin is open-drain two-way, driven low during own reset
// - chip enable high: standby, counter cleared, all data pins floated
// - serial mode presents bitstream on serial data pin when enabled
// - next data appears shortly after each rising clock edge
// - parallel mode presents bytes on all eight data pins when enabled
// - serial mode keeps upper seven data pins floating always
// - chain output low only when enabled and counter passed terminal count
// - chain output returns high when reset low or chip enable high
package cpsr_pkg;
    localparam int ADDR_W      = 10;
    localparam int BYTE_W      = 8;
    localparam int MEM_BYTES   = 1 << ADDR_W;
    localparam int BIT_ADDR_W  = ADDR_W + 3;
    localparam logic [BIT_ADDR_W-1:0] BIT_ZERO = 13'h0000;
    localparam logic [BIT_ADDR_W-1:0] BIT_ONE  = 13'h0001;
    localparam logic [BIT_ADDR_W-1:0] BIT_LAST = 13'h1FFF;
    localparam logic [BIT_ADDR_W-1:0] BYTE_LAST = 13'h03FF;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam int FIFO_DEPTH  = 8;
    localparam int SYNC_LEN    = 3;
    localparam int INT_RST_CYC = 4;
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic              en;
        logic              par;
    } cpsr_out_t;
endpackage : cpsr_pkg

// *** rtl/cpsr_top.sv ***
`timescale 1ns/1ns
module cpsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_reg;
    logic [PW-1:0]    rd_reg;
    logic [PW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (flush_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= PW'(wr_reg + 1'b1);
            end
            if (pop) begin
                rd_reg <= PW'(rd_reg + 1'b1);
            end
            cnt_reg <= (PW+1)'(cnt_reg + push - pop);
        end
    end
endmodule : cpsr_fifo

module cpsr_top
    import cpsr_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,
    // configuration link pins
    input  wire logic              config_clock_i,
    input  wire logic              chip_enable_n_i,
    input  wire logic              oe_reset_n_i,
    output logic                   oe_reset_n_o,
    output logic                   oe_reset_oe_o,
    input  wire logic              parallel_mode_i,
    // data pins
    output logic [BYTE_W-1:0]      byte_out_bus_o,
    output logic [BYTE_W-1:0]      byte_out_oe_o,
    output logic                   chain_select_out_n_o,
    // stored bitstream load port
    input  wire logic              load_we_i,
    input  wire logic [ADDR_W-1:0] load_addr_i,
    input  wire logic [BYTE_W-1:0] load_data_i
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cpsr_state_t;

    logic [1:0]            rst_sync_reg;
    logic                  rst_n;
    logic [SYNC_LEN-1:0]   clk_sync_reg;
    logic [SYNC_LEN-1:0]   ce_sync_reg;
    logic [SYNC_LEN-1:0]   oe_sync_reg;
    logic [SYNC_LEN-1:0]   par_sync_reg;
    logic                  ce_n_reg;
    logic                  oe_reg;
    logic                  par_reg;
    logic                  clk_lvl_reg;
    logic                  rise;
    logic                  active;
    logic [2:0]            irst_reg;
    logic [BIT_ADDR_W-1:0] addr_reg;
    cpsr_state_t           state_reg;
    logic [BYTE_W-1:0]     mem [MEM_BYTES];
    logic [BYTE_W-1:0]     rd_byte;
    logic                  rd_bit;
    logic [BYTE_W-1:0]     f_in;
    logic                  f_in_ready;
    logic                  f_out_valid;
    logic [BYTE_W-1:0]     f_out;
    cpsr_out_t             out_reg;

    // reset release
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_reg <= '0;
            ce_sync_reg  <= '1;
            oe_sync_reg  <= '0;
            par_sync_reg <= '0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], config_clock_i};
            ce_sync_reg  <= {ce_sync_reg[1:0], chip_enable_n_i};
            oe_sync_reg  <= {oe_sync_reg[1:0], oe_reset_n_i};
            par_sync_reg <= {par_sync_reg[1:0], parallel_mode_i};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ce_n_reg    <= 1'b1;
            oe_reg      <= 1'b0;
            par_reg     <= 1'b0;
            clk_lvl_reg <= 1'b0;
        end else begin
            if (ce_sync_reg[1] == ce_sync_reg[2]) ce_n_reg <= ce_sync_reg[2];
            if (oe_sync_reg[1] == oe_sync_reg[2]) oe_reg <= oe_sync_reg[2];
            if (par_sync_reg[1] == par_sync_reg[2]) par_reg <= par_sync_reg[2];
            if (clk_sync_reg[1] == clk_sync_reg[2]) begin
                clk_lvl_reg <= clk_sync_reg[2];
            end
        end
    end
    assign rise = (clk_sync_reg[1] == clk_sync_reg[2])
               && clk_sync_reg[2] && !clk_lvl_reg;
    assign active = !ce_n_reg && oe_reg && (irst_reg == '0);

    // own internal reset holds the shared pin low for a few cycles
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            irst_reg <= 3'(INT_RST_CYC);
        end else if (irst_reg != '0) begin
            irst_reg <= 3'(irst_reg - 1'b1);
        end
    end
    assign oe_reset_n_o  = 1'b0;
    assign oe_reset_oe_o = (irst_reg != '0);

    // stored bitstream
    always_ff @(posedge clk_sys_i) begin
        if (load_we_i) begin
            mem[load_addr_i] <= load_data_i;
        end
    end
    assign rd_byte = par_reg ? mem[addr_reg[ADDR_W-1:0]]
                             : mem[addr_reg[BIT_ADDR_W-1:3]];
    // msb of each byte goes out first in serial mode
    assign rd_bit  = rd_byte[3'h7 - addr_reg[2:0]];
    assign f_in    = par_reg ? rd_byte : {{(BYTE_W-1){1'b0}}, rd_bit};

    // address counter; stalls if the output stage cannot take data
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg  <= BIT_ZERO;
            state_reg <= ST_IDLE;
        end else if (!active) begin
            addr_reg  <= BIT_ZERO;
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (rise && f_in_ready) begin
                        if ((par_reg && addr_reg == BYTE_LAST)
                            || (!par_reg && addr_reg == BIT_LAST)) begin
                            state_reg <= ST_DONE;
                        end else begin
                            addr_reg <= addr_reg + BIT_ONE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_DONE;
                end
            endcase
        end
    end

    // one word per edge: current word queued, popped on the next system clock cycle
    cpsr_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_sys_i),
        .rst_n_i     (rst_n),
        .flush_i     (!active),
        .in_valid_i  (rise && state_reg == ST_RUN),
        .in_ready_o  (f_in_ready),
        .in_data_i   (f_in),
        .out_valid_o (f_out_valid),
        .out_ready_i (1'b1),
        .out_data_o  (f_out)
    );

    // data outputs from flip-flops, a few cycles after the edge
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= '0;
        end else if (!active) begin
            out_reg <= '0;
        end else begin
            out_reg.en  <= 1'b1;
            out_reg.par <= par_reg;
            if (f_out_valid) begin
                out_reg.data <= f_out;
            end
        end
    end

    assign byte_out_bus_o = out_reg.data;
    assign byte_out_oe_o  = out_reg.par
        ? {BYTE_W{out_reg.en}}
        : {{(BYTE_W-1){1'b0}}, out_reg.en};
    assign chain_select_out_n_o = !(active && state_reg == ST_DONE);
endmodule : cpsr_top

// *** verif/cpsr_top_properties.sv ***
`timescale 1ns/1ns
module cpsr_top_checker
    import cpsr_pkg::*;
(
    // watched pins
    input wire logic              clk_sys_i,
    input wire logic              reset_n_i,
    input wire logic              config_clock_i,
    input wire logic              chip_enable_n_i,
    input wire logic              oe_reset_n_i,
    input wire logic              oe_reset_n_o,
    input wire logic              oe_reset_oe_o,
    input wire logic              parallel_mode_i,
    input wire logic [BYTE_W-1:0] byte_out_bus_o,
    input wire logic [BYTE_W-1:0] byte_out_oe_o,
    input wire logic              chain_select_out_n_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    wire en = !chip_enable_n_i && oe_reset_n_i;
    // eight cycles covers the input synchronisers
    sequence s_ser; (en && !parallel_mode_i) [*8]; endsequence
    sequence s_par; (en && parallel_mode_i) [*8]; endsequence
    sequence s_off; chip_enable_n_i [*8]; endsequence
    sequence s_idle; ($stable(config_clock_i) && $stable(en)) [*8]; endsequence
    property p_pin_low; oe_reset_n_o == 1'b0; endproperty
    property p_int_rst; $rose(reset_n_i) |-> ##[1:6] oe_reset_oe_o; endproperty
    // pull spans the reset release flops plus the internal count
    property p_int_len; oe_reset_oe_o [*8] |-> 1'b0; endproperty
    property p_rst_off;
        !oe_reset_n_i [*8] |-> byte_out_oe_o == 8'h00 && chain_select_out_n_o;
    endproperty
    property p_ce_off;
        s_off |-> byte_out_oe_o == 8'h00 && byte_out_bus_o == 8'h00
                  && chain_select_out_n_o;
    endproperty
    property p_ser; s_ser |-> byte_out_oe_o == 8'h01; endproperty
    property p_par; s_par |-> byte_out_oe_o == 8'hFF; endproperty
    property p_chain; $fell(chain_select_out_n_o) |-> en; endproperty
    property p_hold; s_idle |=> $stable(byte_out_bus_o); endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("reset pin drive value not low");
    a_int_rst: assert property (p_int_rst)
        else $error("no internal reset pull after release");
    a_int_len: assert property (p_int_len)
        else $error("internal reset pull too long");
    a_rst_off: assert property (p_rst_off)
        else $error("outputs active while reset pin low");
    a_ce_off: assert property (p_ce_off)
        else $error("outputs active in standby");
    a_ser: assert property (p_ser)
        else $error("serial enables wrong");
    a_par: assert property (p_par)
        else $error("parallel enables wrong");
    a_chain: assert property (p_chain)
        else $error("chain out low while disabled");
    a_hold: assert property (p_hold)
        else $error("data changed without clock rise");
endmodule : cpsr_top_checker

// *** verif/cpsr_target.sv ***
`timescale 1ns/1ns
module cpsr_target (
    // control from bench
    input  wire logic        go_i,
    input  wire logic [15:0] pulses_i,
    input  wire logic        parallel_i,
    // link
    input  wire logic [7:0]  data_i,
    output logic             config_clock_o,
    output logic             busy_o
);
    logic [7:0] cap [$];
    initial begin
        config_clock_o = 1'b0;
        busy_o = 1'b0;
    end
    // clock stands still between frames; 125 ns period
    always @(posedge go_i) begin
        busy_o = 1'b1;
        cap.delete();
        for (int k = 0; k < pulses_i; k++) begin
            #63;
            config_clock_o = 1'b1;
            if (k > 0)
                cap.push_back(parallel_i ? data_i : {7'h00, data_i[0]});
            #62;
            config_clock_o = 1'b0;
        end
        busy_o = 1'b0;
    end
endmodule : cpsr_target

// *** verif/cpsr_top_bench.sv ***
`timescale 1ns/1ns
module cpsr_top_bench
    import cpsr_pkg::*;
();
    logic              clk_sys_i = 1'b0;
    logic              reset_n_i, ce_n, oe_drv, par, we, go, busy, config_clock;
    logic              oe_n_o, oe_oe, chain_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdat, bus, boe, mem [MEM_BYTES];
    logic [15:0]       pulses;
    int                n_fail = 0, checked = 0, seed = 32'h38053b19, n;
    // floating data and reset lines are pulled up
    wire oe_wire = oe_oe ? oe_n_o : oe_drv;
    // shared data net, where a chained device would join
    wire [7:0] wd = (boe & bus) | ~boe;
    always #2 clk_sys_i = ~clk_sys_i;
    cpsr_top i_dut (.clk_sys_i, .reset_n_i, .config_clock_i(config_clock),
        .chip_enable_n_i(ce_n), .oe_reset_n_i(oe_wire), .oe_reset_n_o(oe_n_o),
        .oe_reset_oe_o(oe_oe), .parallel_mode_i(par), .byte_out_bus_o(bus),
        .byte_out_oe_o(boe), .chain_select_out_n_o(chain_n),
        .load_we_i(we), .load_addr_i(addr), .load_data_i(wdat));
    cpsr_target i_tgt (.go_i(go), .pulses_i(pulses), .parallel_i(par),
        .data_i(wd), .config_clock_o(config_clock), .busy_o(busy));
    function automatic logic [7:0] exp_w(input logic p, input int j);
        return p ? mem[j] : {7'h00, mem[j/8][7-j%8]};
    endfunction : exp_w
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_sim;
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys_i);
        #1;
    endtask : tick
    // frame of n pulses; the first rise only launches word 0
    task automatic run(input logic p, input logic ce, input int n, input int s);
        int         lim;
        logic [7:0] e;
        // words past the terminal count are left undefined
        lim = p ? MEM_BYTES : 8 * MEM_BYTES;
        tick(1);
        par = p;
        ce_n = ce;
        tick(10);
        pulses = n[15:0];
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (int w = 0; w < 40000 && busy; w++)
            tick(1);
        if (busy) begin
            n_fail++;
            end_sim();
        end
        // a floated line reads as its pull-up
        for (int j = 0; j < n - 1 && j + s < lim; j++) begin
            e = ce ? (p ? 8'hFF : 8'h01) : exp_w(p, j + s);
            cmp(i_tgt.cap[j], e);
        end
    endtask : run
    initial begin
        {reset_n_i, ce_n, oe_drv, par, we, go} = 6'h18;
        {addr, wdat, pulses} = '0;
        tick(2);
        reset_n_i = 1'b1;
        tick(10);
        for (int a = 0; a < MEM_BYTES; a++) begin
            we = 1'b1;
            addr = a[ADDR_W-1:0];
            wdat = 8'($random(seed));
            mem[a] = wdat;
            tick(1);
        end
        we = 1'b0;
        run(1'b1, 1'b1, 5, 0);
        run(1'b1, 1'b0, MEM_BYTES + 2, 0);
        cmp({7'h00, chain_n}, 8'h00);
        cmp(boe, 8'hFF);
        oe_drv = 1'b0;
        tick(10);
        cmp({7'h00, chain_n}, 8'h01);
        cmp(boe, 8'h00);
        cmp(bus, 8'h00);
        oe_drv = 1'b1;
        run(1'b0, 1'b1, 2, 0);
        cmp({7'h00, chain_n}, 8'h01);
        n = 2 + (($random(seed) & 15));
        run(1'b0, 1'b0, n, 0);
        cmp(boe, 8'h01);
        oe_drv = 1'b0;
        tick(10);
        cmp(boe, 8'h00);
        oe_drv = 1'b1;
        run(1'b0, 1'b0, 17, 0);
        end_sim();
    end
    initial begin
        #300000;
        n_fail++;
        end_sim();
    end
endmodule : cpsr_top_bench
bind cpsr_top cpsr_top_checker i_chk (.clk_sys_i, .reset_n_i,
    .config_clock_i, .chip_enable_n_i, .oe_reset_n_i, .oe_reset_n_o,
    .oe_reset_oe_o, .parallel_mode_i, .byte_out_bus_o, .byte_out_oe_o,
    .chain_select_out_n_o);
